// [lmx_pkg.sv]
// Purpose: constants for the logic/move instruction executor
// Assumes: 12-bit instruction words, 8-bit data path
// Notes:   opcode patterns are matched under masks
package lmx_pkg;
  localparam int          LMX_IW       = 12;
  localparam int          LMX_DW       = 8;
  localparam int          LMX_AW       = 5;
  localparam int          LMX_DBIT     = 5;
  // opcode masks and patterns
  localparam logic [11:0] LMX_M_LIT    = 12'hf00;
  localparam logic [11:0] LMX_P_ORLIT  = 12'hd00;
  localparam logic [11:0] LMX_P_LDLIT  = 12'hc00;
  localparam logic [11:0] LMX_M_FD     = 12'hfc0;
  localparam logic [11:0] LMX_P_ORF    = 12'h100;
  localparam logic [11:0] LMX_P_MOVE_FILE   = 12'h200;
  localparam logic [11:0] LMX_M_ST     = 12'hfe0;
  localparam logic [11:0] LMX_P_ST     = 12'h020;
  localparam logic [11:0] LMX_W_NOP    = 12'h000;
  localparam logic [11:0] LMX_W_TCFG   = 12'h002;
  localparam logic [7:0]  LMX_ACC_RST  = 8'h00;
  localparam logic [7:0]  LMX_TCFG_RST = 8'hff;
  localparam logic [7:0]  LMX_ZERO     = 8'h00;
  typedef enum {LMX_NOP, LMX_ORLIT, LMX_LDLIT, LMX_ORF, LMX_MOVE_FILE, LMX_ST, LMX_TCFG,
                LMX_OTHER} lmx_op_t;
endpackage : lmx_pkg

// [lmx_exec.sv]
// Purpose: execute seven logic/move instruction words in one cycle each
// Assumes: instr_valid_in marks one fetched word per clock; file reads are combinational
// Notes:   other opcodes are ignored here
`timescale 1ns/100ps
// Functional notes
// RULE_01 - or-literal ORs the accumulator with the low byte, writes the accumulator, sets zero flag.
// RULE_02 - or-with-file ORs accumulator with the addressed file, steered by d, sets zero flag.
// RULE_03 - with d clear the result goes to the accumulator and the file is untouched.
// RULE_04 - with d set the result goes back to the file and the accumulator is untouched.
// RULE_05 - move-file copies the file to accumulator or itself per d and sets zero flag from it.
// RULE_06 - move-file with d set still updates the zero flag so software can test for zero.
// RULE_07 - store writes the accumulator to the addressed file and leaves flags alone.
// RULE_08 - timer-config load copies the accumulator to the timer config register in one cycle.
// RULE_09 - load-literal puts the low byte in the accumulator in one cycle, flags unchanged.
// RULE_10 - the all-zero word changes nothing.
module lmx_exec
  import lmx_pkg::*;
#(
  parameter int DW = LMX_DW,
  parameter int AW = LMX_AW
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              instr_valid_in,
  input  wire logic [LMX_IW-1:0] instr_in,
  input  wire logic [DW-1:0]     file_rdata_in,
  output logic      [AW-1:0]     file_addr_out,
  output logic      [DW-1:0]     file_wdata_out,
  output logic                   file_we_out,
  output logic      [DW-1:0]     acc_out,
  output logic                   zero_flag_out,
  output logic      [DW-1:0]     timer_cfg_out
);
  // ==========================================================
  // sampling defaults for the checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ==========================================================
  // parameter check
  if (DW != LMX_DW || AW != LMX_AW) begin : g_width_check
    $error("lmx_exec: unsupported width");
  end

  // ==========================================================
  // decode
  function automatic lmx_op_t lmx_decode(input logic [LMX_IW-1:0] w);
    lmx_op_t op;
    op = LMX_OTHER;
    if (w == LMX_W_NOP)                       op = LMX_NOP;
    else if (w == LMX_W_TCFG)                 op = LMX_TCFG;
    else if ((w & LMX_M_LIT) == LMX_P_ORLIT)  op = LMX_ORLIT;
    else if ((w & LMX_M_LIT) == LMX_P_LDLIT)  op = LMX_LDLIT;
    else if ((w & LMX_M_FD) == LMX_P_ORF)     op = LMX_ORF;
    else if ((w & LMX_M_FD) == LMX_P_MOVE_FILE)    op = LMX_MOVE_FILE;
    else if ((w & LMX_M_ST) == LMX_P_ST)      op = LMX_ST;
    return op;
  endfunction : lmx_decode

  lmx_op_t         op;
  logic [DW-1:0]   lit;
  logic [AW-1:0]   faddr;
  logic            dbit;
  logic [DW-1:0]   acc_ff,    nxt_acc;
  logic            zf_ff,     nxt_zf;
  logic [DW-1:0]   tcfg_ff,   nxt_tcfg;
  logic [AW-1:0]   fa_ff,     nxt_fa;
  logic [DW-1:0]   fwd_ff,    nxt_fwd;
  logic            fwe_ff,    nxt_fwe;
  logic [DW-1:0]   res;

  assign op    = instr_valid_in ? lmx_decode(instr_in) : LMX_NOP;
  assign lit   = instr_in[DW-1:0];
  assign faddr = instr_in[AW-1:0];
  assign dbit  = instr_in[LMX_DBIT];

  // ==========================================================
  // execute
  always_comb begin
    nxt_acc  = acc_ff;
    nxt_zf   = zf_ff;
    nxt_tcfg = tcfg_ff;
    nxt_fa   = instr_valid_in ? faddr : fa_ff;
    nxt_fwd  = fwd_ff;
    nxt_fwe  = 1'b0;
    res      = LMX_ZERO;
    case (op)
      LMX_ORLIT: begin
        res     = acc_ff | lit;                          // RULE_01
        nxt_acc = res;
        nxt_zf  = (res == LMX_ZERO);
      end
      LMX_LDLIT: begin
        nxt_acc = lit;                                   // RULE_09
      end
      LMX_ORF, LMX_MOVE_FILE: begin
        res    = (op == LMX_ORF) ? (acc_ff | file_rdata_in) : file_rdata_in; // RULE_02 RULE_05
        nxt_zf = (res == LMX_ZERO);                      // RULE_06
        if (dbit) begin
          nxt_fwd = res;                                 // RULE_04
          nxt_fwe = 1'b1;
        end else begin
          nxt_acc = res;                                 // RULE_03
        end
      end
      LMX_ST: begin
        nxt_fwd = acc_ff;                                // RULE_07
        nxt_fwe = 1'b1;
      end
      LMX_TCFG: begin
        nxt_tcfg = acc_ff;                               // RULE_08
      end
      LMX_NOP: begin
        nxt_acc = acc_ff;                                // RULE_10
      end
      default: begin
        nxt_acc = acc_ff;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_ff  <= LMX_ACC_RST;
      zf_ff   <= 1'b0;
      tcfg_ff <= LMX_TCFG_RST;
      fa_ff   <= '0;
      fwd_ff  <= LMX_ZERO;
      fwe_ff  <= 1'b0;
    end else begin
      acc_ff  <= nxt_acc;
      zf_ff   <= nxt_zf;
      tcfg_ff <= nxt_tcfg;
      fa_ff   <= nxt_fa;
      fwd_ff  <= nxt_fwd;
      fwe_ff  <= nxt_fwe;
    end
  end

  // file read address is combinational from the word; write port is registered
  assign file_addr_out  = instr_valid_in ? faddr : fa_ff;
  assign file_wdata_out = fwd_ff;
  assign file_we_out    = fwe_ff;
  assign acc_out        = acc_ff;
  assign zero_flag_out  = zf_ff;
  assign timer_cfg_out  = tcfg_ff;

  // ==========================================================
  // assertions
  wire v_orlit = instr_valid_in && (lmx_decode(instr_in) == LMX_ORLIT);
  wire v_ldlit = instr_valid_in && (lmx_decode(instr_in) == LMX_LDLIT);
  wire v_orf   = instr_valid_in && (lmx_decode(instr_in) == LMX_ORF);
  wire v_move_file  = instr_valid_in && (lmx_decode(instr_in) == LMX_MOVE_FILE);
  wire v_st    = instr_valid_in && (lmx_decode(instr_in) == LMX_ST);
  wire v_tcfg  = instr_valid_in && (lmx_decode(instr_in) == LMX_TCFG);
  wire v_nop   = !instr_valid_in || (lmx_decode(instr_in) == LMX_NOP);
  wire v_other = instr_valid_in && (lmx_decode(instr_in) == LMX_OTHER);
  wire v_write = v_st || ((v_orf || v_move_file) && dbit);
  wire v_accw  = v_orlit || v_ldlit || ((v_orf || v_move_file) && !dbit);
  wire v_zupd  = v_orlit || v_orf || v_move_file;

  orlit_result_a: assert property (v_orlit |=> // RULE_01
    acc_ff == ($past(acc_ff) | $past(lit)) && zf_ff == (acc_ff == LMX_ZERO))
    else $error("or literal wrong");
  orf_zero_a: assert property (v_orf |=> // RULE_02
    zf_ff == (($past(acc_ff) | $past(file_rdata_in)) == LMX_ZERO))
    else $error("zero flag wrong");
  dest_acc_a: assert property ((v_orf || v_move_file) && !dbit |=> // RULE_03
    !file_we_out && acc_ff == $past(res))
    else $error("acc destination wrong");
  dest_file_a: assert property ((v_orf || v_move_file) && dbit |=> // RULE_04
    file_we_out && $stable(acc_ff) && file_wdata_out == $past(res))
    else $error("file dest wrong");
  move_file_copy_a: assert property (v_move_file |=> // RULE_05
    ($past(dbit) ? file_wdata_out : acc_ff) == $past(file_rdata_in))
    else $error("move value wrong");
  move_file_test_a: assert property (v_move_file && dbit |=> // RULE_06
    zf_ff == ($past(file_rdata_in) == LMX_ZERO) && file_wdata_out == $past(file_rdata_in))
    else $error("zero test failed");
  store_write_a: assert property (v_st |=> // RULE_07
    file_we_out && file_wdata_out == $past(acc_ff) && $stable(zf_ff) && $stable(acc_ff))
    else $error("store wrong");
  tcfg_load_a: assert property (v_tcfg |=> // RULE_08
    timer_cfg_out == $past(acc_ff) && $stable(zf_ff))
    else $error("timer config wrong");
  ldlit_value_a: assert property (v_ldlit |=> // RULE_09
    acc_ff == $past(lit) && $stable(zf_ff))
    else $error("load literal wrong");
  nop_quiet_a: assert property (v_nop |=> // RULE_10
    $stable(acc_ff) && $stable(zf_ff) && $stable(timer_cfg_out) && !file_we_out)
    else $error("nop changed state");
  other_ignored_a: assert property (v_other |=> // RULE_10
    $stable(acc_ff) && $stable(zf_ff) && $stable(timer_cfg_out) && !file_we_out)
    else $error("unknown word changed state");
  flag_hold_a: assert property (!v_zupd |=> // RULE_07
    $stable(zf_ff))
    else $error("zero flag moved");
  tcfg_hold_a: assert property (!v_tcfg |=> // RULE_08
    $stable(timer_cfg_out))
    else $error("timer config moved");
  write_strobe_a: assert property (v_write |=> // RULE_04
    file_we_out)
    else $error("write strobe missing");
  write_quiet_a: assert property (!v_write |=> // RULE_03
    !file_we_out)
    else $error("spurious write strobe");
  store_addr_a: assert property (v_write |=> // RULE_07
    fa_ff == $past(faddr))
    else $error("write address wrong");
  acc_hold_a: assert property (!v_accw |=> // RULE_04
    $stable(acc_ff))
    else $error("accumulator moved");
  addr_keep_a: assert property (!instr_valid_in |=> // RULE_07
    $stable(fa_ff))
    else $error("write address drifted");

  // ==========================================================
  // cover points
  orf_file_c: cover property (v_orf ##1 v_orf && dbit);
  move_file_zero_c: cover property (v_move_file && dbit && file_rdata_in == LMX_ZERO);
  store_tcfg_c: cover property (v_st ##1 v_tcfg);
  lit_pair_c: cover property (v_ldlit ##1 v_orlit);
  orlit_zero_c: cover property (v_orlit && acc_ff == LMX_ZERO && lit == LMX_ZERO);
endmodule : lmx_exec

// [lmx_file_mem.sv]
// Purpose: data register file model facing the executor
// Assumes: combinational read, write lands at the edge after the strobe
// Notes:   write address is the one taken with the word
`timescale 1ns/100ps
// ====================
// file register model
module lmx_file_mem (
  input  wire logic       clk_in,
  input  wire logic       valid_in,
  input  wire logic [4:0] fsel_in,
  input  wire logic [4:0] addr_in,
  input  wire logic       we_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out
);
  logic [7:0] mem [32];
  logic [4:0] wa_ff;
  initial for (int i = 0; i < 32; i++) mem[i] = 8'(i * 37);
  assign rdata_out = mem[addr_in];
  always @(posedge clk_in) begin
    if (we_in) mem[wa_ff] <= wdata_in;
    if (valid_in) wa_ff <= fsel_in;
  end
endmodule : lmx_file_mem

// [test_logic_move_instr_execute.sv]
// Purpose: self-checking bench for the executor
// Assumes: inputs change on the falling edge
// Notes:   a reference of accumulator, flag and file is kept here
`timescale 1ns/100ps
// ====================
// bench
module test_logic_move_instr_execute;
  import lmx_pkg::*;
  logic clk_in = 0, rst_in = 1, vld = 0, we, zf;
  logic [11:0] ins = 12'h000;
  logic [7:0] rd, wd, acc, tc, ea = 8'h00, et = 8'hff, rm [32];
  logic [4:0] fa;
  logic ez = 0;
  int bad_count = 0, num_checks = 0, cyc = 0;
  initial forever #4 clk_in = ~clk_in;
  lmx_exec DUT (.clk_in(clk_in), .rst_in(rst_in), .instr_valid_in(vld), .instr_in(ins),
    .file_rdata_in(rd), .file_addr_out(fa), .file_wdata_out(wd), .file_we_out(we),
    .acc_out(acc), .zero_flag_out(zf), .timer_cfg_out(tc));
  lmx_file_mem P (.clk_in(clk_in), .valid_in(vld), .fsel_in(ins[4:0]), .addr_in(fa),
    .we_in(we), .wdata_in(wd), .rdata_out(rd));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  always @(posedge clk_in) if (++cyc == 1000) begin bad_count++; close_out; end
  // ====================
  // drive one word, step the reference, compare unless b2b is set
  task automatic run(input logic [11:0] w, input bit b2b = 0);
    logic [4:0] f;
    logic [7:0] r;
    logic       wr;
    f = w[4:0];
    wr = 0;
    @(negedge clk_in);
    vld = 1;
    ins = w;
    if (w[11:8] == 4'hd) begin r = ea | w[7:0]; ea = r; ez = (r == 8'h00); end
    else if (w[11:8] == 4'hc) ea = w[7:0];
    else if (w[11:6] == 6'h04 || w[11:6] == 6'h08) begin
      r = w[9] ? rm[f] : (ea | rm[f]);
      ez = (r == 8'h00);
      if (w[5]) begin rm[f] = r; wr = 1; end
      else ea = r;
    end
    else if (w[11:5] == 7'h01) begin rm[f] = ea; wr = 1; end
    else if (w == 12'h002) et = ea;
    if (b2b) return;
    @(negedge clk_in);
    vld = 0;
    chk("acc", ea, acc);
    chk("zero", 8'(ez), 8'(zf));
    chk("tcfg", et, tc);
    chk("we", 8'(wr), 8'(we));
    chk("addr", 8'(f), 8'(fa));
    if (wr) chk("wdata", rm[f], wd);
    @(negedge clk_in);
    chk("file", rm[f], P.mem[f]);
  endtask : run
  task automatic t_reset;
    chk("acc", 8'h00, acc);
    chk("tcfg", 8'hff, tc);
    chk("we", 8'h00, 8'(we));
    chk("zero", 8'h00, 8'(zf));
    chk("wdata", 8'h00, wd);
    chk("addr", 8'h00, 8'(fa));
    $display("reset done");
  endtask : t_reset
  task automatic t_logic;
    run(12'hc9a);
    run(12'hd35);
    chk("or", 8'hbf, acc);
    run(12'hc00);
    run(12'hd00);
    run(12'h103);
    run(12'h127);
    run(12'h133);
    $display("logic done");
  endtask : t_logic
  task automatic t_move;
    run(12'h205);
    run(12'h220);
    run(12'h229);
    run(12'h02a);
    run(12'h002);
    run(12'h000);
    run(12'h7ff);
    run(12'hc11, 1);
    run(12'hd40, 1);
    run(12'h03f);
    $display("move done");
  endtask : t_move
  task automatic t_burst;
    run(12'h104, 1);
    run(12'h125);
    run(12'h03e, 1);
    run(12'h002);
    chk("file", rm[30], P.mem[30]);
    $display("burst done");
  endtask : t_burst
  task automatic t_midreset;
    @(negedge clk_in);
    rst_in = 1;
    @(negedge clk_in);
    chk("acc", 8'h00, acc);
    chk("zero", 8'h00, 8'(zf));
    chk("tcfg", 8'hff, tc);
    chk("we", 8'h00, 8'(we));
    rst_in = 0;
    ea = 8'h00;
    et = 8'hff;
    ez = 1'b0;
    run(12'hd00);
    $display("mid reset done");
  endtask : t_midreset
  initial begin
    for (int i = 0; i < 32; i++) rm[i] = 8'(i * 37);
    repeat (8) @(posedge clk_in);
    @(negedge clk_in) rst_in = 0;
    t_reset();
    t_logic();
    t_move();
    t_burst();
    t_midreset();
    close_out();
  end
endmodule : test_logic_move_instr_execute
